// >>> hdl/tds_pkg.sv
// package of constants for the thread dependency slot bank
package tds_pkg;
  localparam int          NUM_SLOTS       = 8;
  localparam int          SLOT_WIDTH      = 16;
  localparam int          TAG_WIDTH       = 8;
  localparam int          TAG_LSB         = 0;
  localparam int          FLAG_BIT        = 15;
  localparam logic [3:0]  BANK_TYPE_CODE  = 4'ha;
  localparam logic [3:0]  BANK_REG_CODE   = 4'hb;
  localparam logic [4:0]  SLOT_SUB_LAST   = 5'h07;
  localparam logic [15:0] SLOT_RESET_VAL  = 16'h0000;
  localparam int          DWORD_HI_LSB    = 16;
endpackage

// >>> hdl/tds_slot.sv
// one dependency slot: tag and in-flight flag
`timescale 1ns/1ps
`default_nettype none
module tds_slot
  import tds_pkg::*;
(
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  // dispatch load
  input  wire logic                 load,
  input  wire logic [TAG_WIDTH-1:0] load_tag,
  input  wire logic                 load_flag,
  // clears
  input  wire logic                 retire_hit,
  input  wire logic                 write_clear,
  // state
  output logic      [TAG_WIDTH-1:0] tag_q,
  output logic                      flag_q
);
  logic [TAG_WIDTH-1:0] tag_d;
  logic                 flag_d;

  // dispatch wins; tag changes only at dispatch
  always_comb begin
    tag_d  = tag_q;
    flag_d = flag_q;
    if (load) begin
      tag_d  = load_tag;
      flag_d = load_flag;
    end else if (retire_hit || write_clear) begin
      flag_d = 1'b0;
    end
  end

  // reset gives a known value though none is required
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tag_q  <= SLOT_RESET_VAL[TAG_WIDTH-1:0];
      flag_q <= 1'b0;
    end else begin
      tag_q  <= tag_d;
      flag_q <= flag_d;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/tds_bank.sv
// thread dependency slot bank top
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Operation
// - eight sixteen-bit unsigned word slots live in the register space.
// - register select upper nibble 1010b picks this bank.
// - low nibble 1011 with sub codes 0..7 selects slots, others reserved.
// - a read returns the stored tag in bits 7:0.
// - bits 14:8 always read zero whatever is written.
// - bit 15 is the in-flight flag for the tagged thread.
// - only a dispatch sets a flag.
// - an end-of-thread broadcast for the named thread clears the flag.
// - only a dispatch changes a stored tag.
// - an instruction write clears the flags of its enabled slots from the start slot upward.
// - reads are per word and write masking is per word.
// - pairs pack into dwords, even slot low half, odd slot high half.
module tds_bank
  import tds_pkg::*;
#(
  parameter int SLOTS = NUM_SLOTS
)
(
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  // dispatch from thread dispatcher
  input  wire logic                  dispatch_valid,
  input  wire logic [SLOTS*TAG_WIDTH-1:0] dispatched_thread_tag,
  input  wire logic [SLOTS-1:0]      dispatch_flags,
  // end-of-thread broadcast
  input  wire logic                  retire_valid,
  input  wire logic [TAG_WIDTH-1:0]  retire_tag,
  // instruction read port
  input  wire logic [7:0]            rd_register_select,
  input  wire logic [4:0]            rd_subregister_select,
  output logic      [SLOT_WIDTH-1:0] rd_word_q,
  output logic      [31:0]           rd_dword_q,
  output logic                       rd_hit_q,
  // instruction write port, per-word enables
  input  wire logic                  wr_valid,
  input  wire logic [7:0]            wr_register_select,
  input  wire logic [4:0]            wr_subregister_select,
  input  wire logic [SLOTS-1:0]      wr_word_enable,
  // flags for the conditional send stall logic
  output logic      [SLOTS-1:0]      in_flight_flag
);
  logic [TAG_WIDTH-1:0]  slot_thread_tag_field [SLOTS];
  logic [SLOTS-1:0]      flag_q;
  logic [SLOTS-1:0]      wr_clear;
  logic [SLOT_WIDTH-1:0] word [SLOTS];
  logic                  rd_sel_ok;
  logic                  wr_sel_ok;
  logic [2:0]            rd_idx;
  logic [2:0]            rd_pair;
  logic [SLOT_WIDTH-1:0] rd_word_d;
  logic [31:0]           rd_dword_d;

  //////////////////////////////////////////////////////////////////////////
  // address decode; reserved codes simply miss
  always_comb begin
    rd_sel_ok = (rd_register_select[7:4] == BANK_TYPE_CODE) &&
                (rd_register_select[3:0] == BANK_REG_CODE) &&
                (rd_subregister_select <= SLOT_SUB_LAST);
    wr_sel_ok = (wr_register_select[7:4] == BANK_TYPE_CODE) &&
                (wr_register_select[3:0] == BANK_REG_CODE) &&
                (wr_subregister_select <= SLOT_SUB_LAST);
    rd_idx    = rd_subregister_select[2:0];
    rd_pair   = {rd_idx[2:1], 1'b0};
  end

  //////////////////////////////////////////////////////////////////////////
  // per-slot storage; write enables are per word, indexed by slot number
  genvar g;
  generate
    for (g = 0; g < SLOTS; g++) begin : g_slot
      // write covers slots from origin upward by its word enables
      assign wr_clear[g] = wr_valid && wr_sel_ok &&
                           (g >= int'(wr_subregister_select)) &&
                           wr_word_enable[g];
      tds_slot tds_slot_inst (
        .ref_clk     (ref_clk),
        .reset       (reset),
        .load        (dispatch_valid),
        .load_tag    (dispatched_thread_tag[g*TAG_WIDTH +: TAG_WIDTH]),
        .load_flag   (dispatch_flags[g]),
        .retire_hit  (retire_valid && flag_q[g] &&
                      (retire_tag == slot_thread_tag_field[g])),
        .write_clear (wr_clear[g]),
        .tag_q       (slot_thread_tag_field[g]),
        .flag_q      (flag_q[g])
      );
      // word image: tag low, zeros in 14:8, flag on top
      assign word[g] = {flag_q[g],
                        {(FLAG_BIT-TAG_WIDTH){1'b0}},
                        slot_thread_tag_field[g]};
    end
  endgenerate

  assign in_flight_flag = flag_q;

  //////////////////////////////////////////////////////////////////////////
  // read mux, word and the dword holding it
  always_comb begin
    rd_word_d  = '0;
    rd_dword_d = '0;
    if (rd_sel_ok) begin
      rd_word_d  = word[rd_idx];
      rd_dword_d = {word[rd_pair + 3'h1], word[rd_pair]};
    end
  end

  // registered read data; no indexing or half control here
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_word_q  <= '0;
      rd_dword_q <= '0;
      rd_hit_q   <= 1'b0;
    end else begin
      rd_word_q  <= rd_word_d;
      rd_dword_q <= rd_dword_d;
      rd_hit_q   <= rd_sel_ok;
    end
  end
endmodule
`default_nettype wire

// >>> verif/tds_bank_properties.sv
// checker for the dependency slot bank
`timescale 1ns/1ps
`default_nettype none
module tds_bank_properties #(parameter int SLOTS = 8) (
  // clock, reset and flag sources
  input wire logic ref_clk, reset, dispatch_valid, retire_valid,
  input wire logic [SLOTS-1:0] dispatch_flags, in_flight_flag,
  // access ports
  input wire logic wr_valid, rd_hit_q,
  input wire logic [7:0] rd_register_select, wr_register_select,
  input wire logic [4:0] rd_subregister_select, wr_subregister_select,
  input wire logic [SLOTS-1:0] wr_word_enable,
  input wire logic [15:0] rd_word_q,
  input wire logic [31:0] rd_dword_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic rhit, rflag;
  logic [7:0] wmask;
  // write clears run from the start slot upward
  assign wmask = (wr_valid && wr_register_select == 8'hab &&
    wr_subregister_select < 5'h08) ?
    wr_word_enable & (8'hff << wr_subregister_select) : 8'h00;
  assign rhit = rd_register_select == 8'hab && rd_subregister_select < 5'h08;
  assign rflag = in_flight_flag[rd_subregister_select[2:0]];
  a_dispatch_load: assert property (dispatch_valid |=>
    in_flight_flag == $past(dispatch_flags)) else $error("bad load");
  a_no_self_set: assert property (!dispatch_valid |=>
    (in_flight_flag & ~$past(in_flight_flag)) == 8'h00) else $error("set");
  a_write_clear: assert property (!dispatch_valid && !retire_valid |=>
    in_flight_flag == ($past(in_flight_flag) & ~$past(wmask)))
    else $error("bad write clear");
  a_read_decode: assert property (!$past(reset) |->
    rd_hit_q == $past(rhit)) else $error("bad decode");
  a_miss_zero: assert property (!rd_hit_q |->
    rd_word_q == 16'h0000 && rd_dword_q == 32'h0) else $error("miss data");
  a_mbz_zero: assert property (rd_word_q[14:8] == 7'h00 &&
    rd_dword_q[30:24] == 7'h00 && rd_dword_q[14:8] == 7'h00)
    else $error("nonzero reserved bits");
  a_word_flag: assert property (rd_hit_q && !$past(reset) |->
    rd_word_q[15] == $past(rflag)) else $error("bad flag read");
  a_dword_pack: assert property (rd_hit_q |-> rd_word_q ==
    ($past(rd_subregister_select[0]) ? rd_dword_q[31:16] : rd_dword_q[15:0]))
    else $error("bad pairing");
  c_load: cover property (dispatch_valid);
  c_write: cover property (wmask != 8'h00);
  c_read: cover property (rd_hit_q && rd_word_q[15]);
  c_retire: cover property (retire_valid && in_flight_flag != 8'h00);
endmodule
`default_nettype wire

// >>> verif/tds_disp_model.sv
// dispatcher and end-of-thread broadcast model
`timescale 1ns/1ps
`default_nettype none
module tds_disp_model (
  input  wire logic ref_clk,
  output logic        dispatch_valid = 1'b0,
  output logic [63:0] dispatched_thread_tag = '0,
  output logic [7:0]  dispatch_flags = '0,
  output logic        retire_valid = 1'b0,
  output logic [7:0]  retire_tag = '0
);
  // one-cycle events; lines inverted after release to expose stale use
  task automatic dispatch(input logic [63:0] t, input logic [7:0] f);
    @(posedge ref_clk);
    dispatch_valid <= 1'b1;
    dispatched_thread_tag <= t;
    dispatch_flags <= f;
    @(posedge ref_clk);
    dispatch_valid <= 1'b0;
    dispatched_thread_tag <= ~t;
    dispatch_flags <= ~f;
  endtask
  task automatic retire(input logic [7:0] t);
    @(posedge ref_clk);
    retire_valid <= 1'b1;
    retire_tag <= t;
    @(posedge ref_clk);
    retire_valid <= 1'b0;
    retire_tag <= ~t;
  endtask
endmodule
`default_nettype wire

// >>> verif/tds_bank_test.sv
// self-checking bench for the dependency slot bank
`timescale 1ns/1ps
`default_nettype none
module tds_bank_test;
  logic ref_clk = 1'b0, reset = 1'b1, wr_valid = 1'b0, rd_hit_q;
  logic [7:0] rd_register_select = 8'h00, wr_register_select = 8'h00;
  logic [4:0] rd_subregister_select = 5'h00, wr_subregister_select = 5'h00;
  logic [7:0] wr_word_enable = 8'h00, in_flight_flag, retire_tag;
  logic dispatch_valid, retire_valid;
  logic [63:0] dispatched_thread_tag;
  logic [7:0] dispatch_flags;
  logic [15:0] rd_word_q;
  logic [31:0] rd_dword_q;
  int err_total = 0, total_checks = 0;
  always #4 ref_clk = ~ref_clk;
  tds_bank tds_bank_inst (.*);
  tds_disp_model tds_disp_model_inst (.*);
  // one compare for every result, widened to a dword
  task automatic chk(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  // slot word after the standard load, tag 10h plus slot number
  function automatic logic [15:0] sw(input int g, input logic f);
    return {f, 7'h00, 8'h10 + 8'(g)};
  endfunction
  task automatic rd(input logic [7:0] r, input logic [4:0] s,
                    input logic [31:0] ew, ed);
    @(posedge ref_clk);
    rd_register_select <= r;
    rd_subregister_select <= s;
    @(posedge ref_clk);
    #1 chk(rd_word_q, ew);
    chk({31'h0, rd_hit_q}, {31'h0, r == 8'hab && s < 5'h08});
    chk(rd_dword_q, ed);
  endtask
  task automatic wr(input logic [4:0] s, input logic [7:0] en);
    @(posedge ref_clk);
    wr_valid <= 1'b1;
    wr_register_select <= 8'hab;
    wr_subregister_select <= s;
    wr_word_enable <= en;
    @(posedge ref_clk);
    wr_valid <= 1'b0;
  endtask
  // load every slot, read back, then reserved codes
  task automatic t_load;
    tds_disp_model_inst.dispatch(64'h1716151413121110, 8'hff);
    #1 chk(in_flight_flag, 8'hff);
    for (int g = 0; g < 8; g++)
      rd(8'hab, 5'(g), sw(g, 1), {sw(g | 1, 1), sw(g & 6, 1)});
    rd(8'hab, 5'h08, 0, 0);
    rd(8'hbb, 5'h00, 0, 0);
  endtask
  // write from slot 5 up: only enabled flags drop, tags stay
  task automatic t_write;
    wr(5'h05, 8'h6f);
    #1 chk(in_flight_flag, 8'h9f);
    rd(8'hab, 5'h05, sw(5, 0), {sw(5, 0), sw(4, 1)});
    wr(5'h09, 8'hff);
    #1 chk(in_flight_flag, 8'h9f);
  endtask
  // retire slot 7's thread, then an unknown one
  task automatic t_retire;
    tds_disp_model_inst.retire(8'h17);
    #1 chk(in_flight_flag, 8'h1f);
    tds_disp_model_inst.retire(8'h40);
    #1 chk(in_flight_flag, 8'h1f);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    t_load();
    t_write();
    t_retire();
    test_done();
  end
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
endmodule
bind tds_bank tds_bank_properties #(.SLOTS(SLOTS)) tds_bank_properties_inst (.*);
`default_nettype wire
